// ---- core/buck_one_ramp.v ----
`timescale 1ns/100ps
`default_nettype none
`include "buck_regs_consts.vh"

module buck_one_ramp #(
  parameter [13:0] SLOW_STEP_CYCLES = 14'd12500,
  parameter [4:0] DEFAULT_CODE = `DEF_CODE_A
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control fields
  input wire go,
  input wire select,
  input wire [4:0] code_a,
  input wire [4:0] code_b,
  input wire [3:0] rate,
  // converter side
  output reg [4:0] present_code,
  output reg ext_ctrl,
  output reg ramping
);

  localparam [4:0] START_CODE =
    (DEFAULT_CODE > `CODE_MAX) ? `CODE_MAX : DEFAULT_CODE;
  localparam START_EXT = (DEFAULT_CODE == `CODE_EXT_CTRL);

  // ==========================================================
  // cycles per 50 mV code step for each rate code
  wire [13:0] step_cycles [0:15];
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_rate
      localparam integer R = (i > 10) ? 10 : ((i == 0) ? 1 : i);
      localparam integer C = SLOW_STEP_CYCLES / R;
      assign step_cycles[i] = (C < 1) ? 14'd1 : C[13:0]; // R10
    end
  endgenerate

  // ==========================================================
  // target selection and ramp
  wire [4:0] target_raw = select ? code_b : code_a; // R3
  wire [4:0] target = (target_raw > `CODE_MAX) ? `CODE_MAX : target_raw; // R6
  reg [13:0] cnt;
  wire [13:0] cnt_inc = cnt + 14'd1;
  wire [13:0] step_len = step_cycles[rate];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      present_code <= START_CODE;
      ext_ctrl <= START_EXT;
      ramping <= 1'b0;
      cnt <= 14'h0000;
    end else if (!go) begin
      ramping <= 1'b0; // R4
      cnt <= 14'h0000;
    end else if (target_raw == `CODE_EXT_CTRL) begin
      ext_ctrl <= 1'b1; // R8
      ramping <= 1'b0;
      cnt <= 14'h0000;
    end else begin
      ext_ctrl <= 1'b0;
      if (present_code == target) begin
        ramping <= 1'b0;
        cnt <= 14'h0000;
      end else if (rate == 4'h0) begin
        present_code <= target; // R10
        ramping <= 1'b0;
        cnt <= 14'h0000;
      end else begin
        ramping <= 1'b1; // R4
        if (cnt_inc >= step_len) begin
          cnt <= 14'h0000;
          if (present_code < target) begin
            present_code <= present_code + 5'h01; // R10
          end else begin
            present_code <= present_code - 5'h01;
          end
        end else begin
          cnt <= cnt_inc;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- core/buck_regs_consts.vh ----
`ifndef BUCK_REGS_CONSTS_VH
`define BUCK_REGS_CONSTS_VH

// ==========================================================
// register offsets
`define OFS_OUTPUT_STATUS 8'h11
`define OFS_VOLTAGE_CHANGE 8'h20
`define OFS_BUCK_ONE_TARGET_A 8'h23
`define OFS_BUCK_ONE_TARGET_B 8'h24
`define OFS_BUCK_ONE_RAMP_RATE 8'h25

// ==========================================================
// status bit positions
`define ST_BUCK_ONE 0
`define ST_BUCK_TWO 2
`define ST_LINEAR_ONE 4
`define ST_LINEAR_TWO 5
`define ST_ALL_LINEAR 6
`define ST_ALL_BUCKS 7

// ==========================================================
// voltage change control bit positions
`define VC_BUCK_ONE_GO 0
`define VC_BUCK_ONE_SEL 1
`define VC_BUCK_TWO_GO 4
`define VC_BUCK_TWO_SEL 5

// ==========================================================
// reset values and field limits
`define RST_STATUS 8'h00
`define RST_VOLTAGE_CHANGE 4'h0
`define RST_RAMP_RATE 4'h8
`define DEF_CODE_A 5'h09
`define DEF_CODE_B 5'h09
`define CODE_EXT_CTRL 5'h00
`define CODE_MAX 5'h19
`define RATE_MAX 4'hA
`define DEVICE_ADDR 7'h60

// ==========================================================
// ramp timing
`define CLK_PERIOD_NS 4
`define BUCK_ONE_STEP_MV 50
`define NS_PER_US 1000

`endif

// ---- core/buck_voltage_regs.v ----
// Behaviour
// R1 - read-only status register, 1 means output valid, all bits reset to 0
// R2 - status bits: buck1 D0, buck2 D2, lin1 D4, lin2 D5, D6, D7
// R3 - control select bit picks target A when 0, target B when 1
// R4 - control go bit 0 holds the output, 1 ramps to selected target
// R5 - all control register bits, reserved included, reset to 0
// R6 - target A 5-bit code, 1..25 maps 0.80-2.00 V, above 25 clamps
// R7 - target B uses the same 5-bit encoding, upper bits reserved
// R8 - code zero in either target hands voltage to external control
// R9 - reserved target bits reset to zero, code loads a factory default
// R10 - ramp moves at 4-bit rate code, 0 instant, else 1..10 mV/us
// R11 - writes to reserved bits ignored, they read back reset values
`timescale 1ns/100ps
`default_nettype none
`include "buck_regs_consts.vh"

module buck_voltage_regs #(
  parameter [6:0] DEVICE_ADDR = `DEVICE_ADDR,
  parameter [4:0] DEFAULT_CODE_A = `DEF_CODE_A,
  parameter [4:0] DEFAULT_CODE_B = `DEF_CODE_B,
  parameter [13:0] SLOW_STEP_CYCLES =
    `BUCK_ONE_STEP_MV * `NS_PER_US / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // serial register bus
  input wire SCL,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  // regulator valid comparators
  input wire BUCK_ONE_OK,
  input wire BUCK_TWO_OK,
  input wire LINEAR_ONE_OK,
  input wire LINEAR_TWO_OK,
  // buck one converter control
  output wire [4:0] BUCK_ONE_CODE,
  output wire BUCK_ONE_EXT_CTRL,
  output wire BUCK_ONE_RAMPING,
  // buck two control fields
  output reg BUCK_TWO_TARGET_SELECT,
  output reg BUCK_TWO_RAMP_GO
);

  // ==========================================================
  // reset release
  reg rst_meta;
  reg rst_n;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // input synchronisers
  reg [5:0] sync_meta;
  reg [5:0] sync;
  reg scl_d;
  reg sda_d;
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= 6'h03;
      sync <= 6'h03;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync_meta <= {LINEAR_TWO_OK, LINEAR_ONE_OK, BUCK_TWO_OK, BUCK_ONE_OK,
                    SDA_IN, SCL};
      sync <= sync_meta;
      scl_d <= sync[0];
      sda_d <= sync[1];
    end
  end

  wire scl_s = sync[0];
  wire sda_s = sync[1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================
  // status register
  reg [7:0] status;
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      status <= `RST_STATUS; // R1
    end else begin
      status <= 8'h00; // R2
      status[`ST_BUCK_ONE] <= sync[2]; // R2
      status[`ST_BUCK_TWO] <= sync[3];
      status[`ST_LINEAR_ONE] <= sync[4];
      status[`ST_LINEAR_TWO] <= sync[5];
      status[`ST_ALL_LINEAR] <= sync[4] & sync[5];
      status[`ST_ALL_BUCKS] <= sync[2] & sync[3];
    end
  end

  // ==========================================================
  // writable registers
  reg buck_one_ramp_go;
  reg buck_one_target_select;
  reg [4:0] buck_one_code_a;
  reg [4:0] buck_one_code_b;
  reg [3:0] buck_one_ramp_rate;
  reg wr_en;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      {BUCK_TWO_TARGET_SELECT, BUCK_TWO_RAMP_GO, buck_one_target_select,
       buck_one_ramp_go} <= `RST_VOLTAGE_CHANGE; // R5
      buck_one_code_a <= DEFAULT_CODE_A; // R9
      buck_one_code_b <= DEFAULT_CODE_B; // R9
      buck_one_ramp_rate <= `RST_RAMP_RATE;
    end else if (wr_en) begin
      case (wr_addr)
        `OFS_VOLTAGE_CHANGE: begin
          buck_one_ramp_go <= wr_data[`VC_BUCK_ONE_GO]; // R4
          buck_one_target_select <= wr_data[`VC_BUCK_ONE_SEL]; // R3
          BUCK_TWO_RAMP_GO <= wr_data[`VC_BUCK_TWO_GO]; // R4
          BUCK_TWO_TARGET_SELECT <= wr_data[`VC_BUCK_TWO_SEL]; // R3
        end
        `OFS_BUCK_ONE_TARGET_A: buck_one_code_a <= wr_data[4:0]; // R6
        `OFS_BUCK_ONE_TARGET_B: buck_one_code_b <= wr_data[4:0]; // R7
        `OFS_BUCK_ONE_RAMP_RATE: buck_one_ramp_rate <= wr_data[3:0]; // R10
        `OFS_OUTPUT_STATUS: begin
          // status is read-only, a write to it changes nothing
          buck_one_ramp_rate <= buck_one_ramp_rate; // R1
        end
        default: buck_one_ramp_rate <= buck_one_ramp_rate; // R11
      endcase
    end
  end

  // ==========================================================
  // read multiplexer, reserved and unmapped bits read zero
  // register pointer, set by the pointer byte, advanced per data byte
  reg [7:0] rd_ptr;
  reg [7:0] rd_data;
  always @* begin
    rd_data = 8'h00;
    case (rd_ptr)
      `OFS_OUTPUT_STATUS: rd_data = status; // R1
      `OFS_VOLTAGE_CHANGE: begin
        rd_data[`VC_BUCK_ONE_GO] = buck_one_ramp_go; // R11
        rd_data[`VC_BUCK_ONE_SEL] = buck_one_target_select;
        rd_data[`VC_BUCK_TWO_GO] = BUCK_TWO_RAMP_GO;
        rd_data[`VC_BUCK_TWO_SEL] = BUCK_TWO_TARGET_SELECT;
      end
      `OFS_BUCK_ONE_TARGET_A: rd_data = {3'h0, buck_one_code_a}; // R11
      `OFS_BUCK_ONE_TARGET_B: rd_data = {3'h0, buck_one_code_b}; // R11
      `OFS_BUCK_ONE_RAMP_RATE: rd_data = {4'h0, buck_one_ramp_rate};
      default: rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // serial bus slave
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_ADDR_ACK = 9'h004;
  localparam [8:0] S_PTR = 9'h008;
  localparam [8:0] S_PTR_ACK = 9'h010;
  localparam [8:0] S_WDATA = 9'h020;
  localparam [8:0] S_WDATA_ACK = 9'h040;
  localparam [8:0] S_RDATA = 9'h080;
  localparam [8:0] S_RDATA_ACK = 9'h100;

  reg [8:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg read_mode;

  // the first byte names this device in its upper seven bits
  wire addr_hit = (shift[7:1] == DEVICE_ADDR);

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      read_mode <= 1'b0;
      rd_ptr <= 8'h00;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      SDA_OUT <= 1'b0;
      // a start or stop ends any transfer, a partial byte is dropped
      if (bus_start) begin
        state <= S_ADDR;
        bit_cnt <= 4'h0;
        SDA_OE <= 1'b0;
      end else if (bus_stop) begin
        state <= S_IDLE;
        SDA_OE <= 1'b0;
      end else begin
        case (state)
          S_IDLE: SDA_OE <= 1'b0;
          S_ADDR, S_PTR, S_WDATA: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              SDA_OE <= 1'b1;
              if (state == S_ADDR) begin
                if (addr_hit) begin
                  read_mode <= shift[0];
                  state <= S_ADDR_ACK;
                end else begin
                  SDA_OE <= 1'b0;
                  state <= S_IDLE;
                end
              end else if (state == S_PTR) begin
                rd_ptr <= shift;
                state <= S_PTR_ACK;
              end else begin
                wr_en <= 1'b1;
                wr_addr <= rd_ptr;
                wr_data <= shift;
                rd_ptr <= rd_ptr + 8'h01;
                state <= S_WDATA_ACK;
              end
            end
          end
          S_ADDR_ACK, S_RDATA_ACK: begin
            // a high data line at the ack clock is the host's nack
            if (scl_rise && state == S_RDATA_ACK && sda_s) begin
              state <= S_IDLE;
            end else if (scl_fall) begin
              if (read_mode) begin
                shift <= rd_data;
                SDA_OE <= ~rd_data[7];
                rd_ptr <= rd_ptr + 8'h01;
                bit_cnt <= 4'h0;
                state <= S_RDATA;
              end else begin
                SDA_OE <= 1'b0;
                state <= S_PTR;
              end
            end
          end
          S_PTR_ACK, S_WDATA_ACK: begin
            if (scl_fall) begin
              SDA_OE <= 1'b0;
              state <= S_WDATA;
            end
          end
          S_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                SDA_OE <= 1'b0;
                state <= S_RDATA_ACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                SDA_OE <= ~shift[6];
              end
            end
          end
          default: begin
            SDA_OE <= 1'b0;
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // buck one target and ramp engine
  buck_one_ramp #(
    .SLOW_STEP_CYCLES(SLOW_STEP_CYCLES),
    .DEFAULT_CODE(DEFAULT_CODE_A)
  ) u_ramp (
    .clk(CLK),
    .rst_n(rst_n),
    .go(buck_one_ramp_go),
    .select(buck_one_target_select),
    .code_a(buck_one_code_a),
    .code_b(buck_one_code_b),
    .rate(buck_one_ramp_rate),
    .present_code(BUCK_ONE_CODE),
    .ext_ctrl(BUCK_ONE_EXT_CTRL),
    .ramping(BUCK_ONE_RAMPING)
  );

endmodule
`default_nettype wire

// ---- test/buck_voltage_regs_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module buck_voltage_regs_monitor #(
  parameter [13:0] SLOW_STEP_CYCLES = 14'd20,
  parameter [4:0] DEFAULT_CODE_A = 5'h09
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // watched ports
  input wire logic SCL,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic [4:0] BUCK_ONE_CODE,
  input wire logic BUCK_ONE_EXT_CTRL,
  input wire logic BUCK_ONE_RAMPING,
  input wire logic BUCK_TWO_TARGET_SELECT,
  input wire logic BUCK_TWO_RAMP_GO
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // cycles spent ramping without a code step
  logic [14:0] stall;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      stall <= 15'h0000;
    else if (BUCK_ONE_RAMPING && $stable(BUCK_ONE_CODE))
      stall <= stall + 15'h0001;
    else
      stall <= 15'h0000;
  end
  sequence s_step;
    $past(BUCK_ONE_RAMPING) && $changed(BUCK_ONE_CODE);
  endsequence
  sequence s_b2_change;
    $changed(BUCK_TWO_TARGET_SELECT) || $changed(BUCK_TWO_RAMP_GO);
  endsequence
  // ==========================================================
  AST_SDA_LOW: assert property (SDA_OUT == 1'b0)
    else $error("data line driven high");
  AST_OE_SCL_LOW: assert property ($changed(SDA_OE) |-> !SCL)
    else $error("data line moved while bus clock high");
  AST_CODE_RANGE: assert property (BUCK_ONE_CODE inside {[1:25]})
    else $error("buck one code outside 1 to 25");
  AST_RAMP_BOUND: assert property (stall <= SLOW_STEP_CYCLES)
    else $error("ramp stalled too long");
  AST_STEP_ONE: assert property (s_step |->
    (BUCK_ONE_CODE == $past(BUCK_ONE_CODE) + 5'h01) ||
    (BUCK_ONE_CODE == $past(BUCK_ONE_CODE) - 5'h01))
    else $error("ramp step larger than one code");
  AST_EXT_HOLD: assert property (BUCK_ONE_EXT_CTRL &&
    $past(BUCK_ONE_EXT_CTRL) |-> $stable(BUCK_ONE_CODE))
    else $error("code moved under external control");
  AST_B2_ON_WRITE: assert property (s_b2_change |-> !SCL)
    else $error("buck two field changed outside a write");
  AST_RST_B2: assert property ($rose(RST_N) |->
    !BUCK_TWO_TARGET_SELECT && !BUCK_TWO_RAMP_GO)
    else $error("buck two fields not cleared by reset");
  AST_RST_CODE: assert property ($rose(RST_N) |->
    BUCK_ONE_CODE == DEFAULT_CODE_A && !BUCK_ONE_RAMPING)
    else $error("buck one code not at default after reset");
endmodule
bind buck_voltage_regs buck_voltage_regs_monitor #(
  .SLOW_STEP_CYCLES(SLOW_STEP_CYCLES),
  .DEFAULT_CODE_A(DEFAULT_CODE_A)
) u_buck_voltage_regs_monitor (
  .CLK(CLK),
  .RST_N(RST_N),
  .SCL(SCL),
  .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE),
  .BUCK_ONE_CODE(BUCK_ONE_CODE),
  .BUCK_ONE_EXT_CTRL(BUCK_ONE_EXT_CTRL),
  .BUCK_ONE_RAMPING(BUCK_ONE_RAMPING),
  .BUCK_TWO_TARGET_SELECT(BUCK_TWO_TARGET_SELECT),
  .BUCK_TWO_RAMP_GO(BUCK_TWO_RAMP_GO)
);
`default_nettype wire

// ---- test/buck_voltage_regs_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module buck_voltage_regs_tb_top;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [3:0] ok = 4'h0;
  logic [4:0] code;
  logic ext, ramp, sel2, go2, scl, sda_drv, sda_oe, sda_out;
  logic [7:0] rd;
  int error_cnt = 0;
  int checked = 0;
  // valid inputs {lin2, lin1, buck2, buck1} beside the status they give
  logic [11:0] rows [8] = '{12'h000, 12'h101, 12'h204, 12'h385,
    12'h410, 12'h820, 12'hC70, 12'hFF5};
  wire sda = sda_drv & ~sda_oe;
  always #2 CLK = ~CLK;
  serial_host u_serial_host (.clk(CLK), .scl(scl), .sda_drv(sda_drv),
    .sda(sda));
  buck_voltage_regs #(.SLOW_STEP_CYCLES(14'd20)) u_buck_voltage_regs (
    .CLK(CLK), .RST_N(RST_N), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .BUCK_ONE_OK(ok[0]), .BUCK_TWO_OK(ok[1]),
    .LINEAR_ONE_OK(ok[2]), .LINEAR_TWO_OK(ok[3]), .BUCK_ONE_CODE(code),
    .BUCK_ONE_EXT_CTRL(ext), .BUCK_ONE_RAMPING(ramp),
    .BUCK_TWO_TARGET_SELECT(sel2), .BUCK_TWO_RAMP_GO(go2));
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_serial_host.reg_read(a, rd);
    `CHK(rd, e)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_serial_host.reg_write(a, d);
  endtask
  task automatic settle();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge CLK);
      if (ramp === 1'b0)
        break;
    end
    if (i == 400) begin
      error_cnt++;
      complete_run();
    end
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (6) @(posedge CLK);
    for (int r = 0; r < 8; r++) begin
      ok <= rows[r][11:8];
      repeat (4) @(posedge CLK);
      rdchk(8'h11, rows[r][7:0]);
    end
    rdchk(8'h20, 8'h00);
    rdchk(8'h23, 8'h09);
    rdchk(8'h24, 8'h09);
    wr(8'h20, 8'hCC);
    rdchk(8'h20, 8'h00);
    wr(8'h20, 8'h30);
    `CHK({sel2, go2}, 2'b11)
    rdchk(8'h20, 8'h30);
    wr(8'h23, 8'hFF);
    rdchk(8'h23, 8'h1F);
    wr(8'h24, 8'h00);
    wr(8'h20, 8'h01);
    settle();
    `CHK(code, 5'h19)
    wr(8'h20, 8'h03);
    `CHK({ext, code}, 6'h39)
    wr(8'h25, 8'h00);
    wr(8'h24, 8'h01);
    `CHK({ext, code}, 6'h01)
    wr(8'h20, 8'h00);
    wr(8'h23, 8'h05);
    `CHK(code, 5'h01)
    rdchk(8'h30, 8'h00);
    wr(8'h11, 8'h00);
    rdchk(8'h11, 8'hF5);
    `CHK(u_serial_host.nak, 1'b0)
    wr(8'h25, 8'hF1);
    rdchk(8'h25, 8'h01);
    wr(8'h20, 8'h01);
    `CHK(ramp, 1'b1)
    settle();
    `CHK(code, 5'h05)
    RST_N <= 1'b0;
    repeat (3) @(posedge CLK);
    `CHK({ext, ramp, code}, 7'h09)
    RST_N <= 1'b1;
    repeat (6) @(posedge CLK);
    rdchk(8'h20, 8'h00);
    rdchk(8'h23, 8'h09);
    rdchk(8'h25, 8'h08);
    complete_run();
  end
endmodule
`default_nettype wire

// ---- test/serial_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_host (
  // clock
  input wire logic clk,
  // bus lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  logic nak;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    nak = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves only well after the clock fall, never near it
  task automatic bits9(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      wt(4);
      sda_drv <= o[k];
      wt(8);
      scl <= 1'b1;
      wt(10);
      i[k] = sda;
      scl <= 1'b0;
    end
  endtask
  task automatic start();
    wt(4);
    sda_drv <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(10);
    sda_drv <= 1'b0;
    wt(10);
    scl <= 1'b0;
  endtask
  task automatic stop();
    wt(4);
    sda_drv <= 1'b0;
    wt(8);
    scl <= 1'b1;
    wt(10);
    sda_drv <= 1'b1;
    wt(10);
  endtask
  task automatic put(input logic [7:0] b);
    logic [8:0] r;
    bits9({b, 1'b1}, r);
    nak = nak | r[0];
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    start();
    put(8'hC0);
    put(a);
    put(d);
    stop();
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r;
    start();
    put(8'hC0);
    put(a);
    start();
    put(8'hC1);
    bits9(9'h1FF, r);
    d = r[8:1];
    stop();
  endtask
endmodule
`default_nettype wire
